// file: hw/tmc_pkg.sv
// Register map, field positions and encodings of the 32-bit match/capture timer.
package tmc_pkg;
  localparam int unsigned ADDR_W    = 12;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned NUM_MATCH = 4;
  localparam int unsigned NUM_FLAGS = 5;

  localparam logic [ADDR_W-1:0] OFS_FLAGS    = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_COUNT    = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_LIMIT    = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_DIVCNT   = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_ACTION   = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_MATCH0   = 12'h018;
  localparam logic [ADDR_W-1:0] MATCH_STRIDE = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_CAPCTL   = 12'h028;
  localparam logic [ADDR_W-1:0] OFS_CAPTURE  = 12'h02C;
  localparam logic [ADDR_W-1:0] OFS_EXTMATCH = 12'h03C;
  localparam logic [ADDR_W-1:0] OFS_SOURCE   = 12'h070;
  localparam logic [ADDR_W-1:0] OFS_PULSE    = 12'h074;
  localparam logic [ADDR_W-1:0] OFS_MASK     = 12'h078;

  localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;

  localparam int unsigned CTRL_EN  = 0;
  localparam int unsigned CTRL_RST = 1;
  localparam int unsigned FLAG_CAP = 4;
  localparam int unsigned ACT_INT  = 0;
  localparam int unsigned ACT_RST  = 1;
  localparam int unsigned ACT_STOP = 2;
  localparam int unsigned ACT_W    = 3;
  localparam int unsigned CAP_RISE = 0;
  localparam int unsigned CAP_FALL = 1;
  localparam int unsigned CAP_INT  = 2;
  localparam int unsigned EXT_LSB  = 4;
  localparam int unsigned EXT_W    = 2;

  localparam logic [1:0] SRC_TIMER = 2'h0;
  localparam logic [1:0] SRC_RISE  = 2'h1;
  localparam logic [1:0] SRC_FALL  = 2'h2;
  localparam logic [1:0] SRC_BOTH  = 2'h3;

  localparam logic [1:0] EXT_NONE   = 2'h0;
  localparam logic [1:0] EXT_LOW    = 2'h1;
  localparam logic [1:0] EXT_HIGH   = 2'h2;
  localparam logic [1:0] EXT_TOGGLE = 2'h3;
endpackage : tmc_pkg

// file: hw/tmc_edge_if.sv
// Edge events of the synchronised capture pin.
`timescale 1ns/1ps
interface tmc_edge_if;
  logic rise;
  logic fall;
  modport src (output rise, output fall);
  modport dst (input rise, input fall);
endinterface : tmc_edge_if

// file: hw/tmc_edge.sv
// Two-flop synchroniser and edge detector for the capture pin.
`timescale 1ns/1ps
module tmc_edge (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic clk_en,
  input  wire logic pin,
  tmc_edge_if.src   edges
);
  logic meta;
  logic sync;
  logic last;

  // The first stage feeds only the second; edges are taken from later stages.
  always_ff @(posedge clk) begin
    if (reset) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end else if (clk_en) begin
      meta <= pin;
      sync <= meta;
      last <= sync;
    end
  end

  assign edges.rise = clk_en & sync & ~last;
  assign edges.fall = clk_en & ~sync & last;

  // One pin change must give exactly one event, or a single edge would count twice.
  edge_excl_a: assert property (@(posedge clk) disable iff (reset) // [R5]
    !(edges.rise && edges.fall) and (edges.rise |=> !edges.rise)
    and (edges.fall |=> !edges.fall)) else $error("edge events overlap or repeat");
endmodule : tmc_edge

// file: hw/tmc_timer32.sv
// 32-bit timer with prescaler, four match channels, one capture input and interrupts.
//
// How it works
// R1: Counter steps on clock-derived ticks or on external input edges, as configured.
// R2: Four match values; a match can raise an interrupt or other action.
// R3: One capture channel stores the count on an input transition, optional interrupt.
// R4: Pulse mode: match channels set outputs high; a resetting match sets cycle length.
// R5: Configured capture pin edge copies the count into the capture register.
// R6: Capture input can replace the prescaled clock as counting source.
// R7: On match, each output toggles, goes low, goes high or holds.
// R8: Each instance has its own clock gate; gated off, everything freezes.
// R9: Flag register shows five pending sources; writing ones clears them.
// R10: Control register disables the counter or holds it in reset.
// R11: Count increments once every divider limit plus one ticks.
// R12: Divider count equal to limit: next tick bumps count, clears divider.
// R13: Divider count is readable and writable by software.
// R14: Instances are identical; only their base address differs.
// R15: Per match: reset count, stop count and divider, and/or interrupt.
// R16: Source control picks timer or counter mode and the counted edges.
// R17: Disabled counter and divider keep their values until enabled or reset.
// R18: Count wraps from all ones to zero.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module tmc_timer32 import tmc_pkg::*; #(
  parameter int unsigned CNT_W = 32
) (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 clk_en,
  input  wire logic [ADDR_W-1:0]    addr,
  input  wire logic [DATA_W-1:0]    wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  input  wire logic                 capture_input,
  output logic      [DATA_W-1:0]    rdata,
  output logic                      irq,
  output logic      [NUM_MATCH-1:0] match_outputs
);
  if (CNT_W != DATA_W) begin : g_width_check
    $error("CNT_W must equal the 32-bit register width");
  end

  logic [NUM_FLAGS-1:0]       flags;
  logic [NUM_FLAGS-1:0]       mask;
  logic [1:0]                 ctrl;
  logic [CNT_W-1:0]           count;
  logic [CNT_W-1:0]           limit;
  logic [CNT_W-1:0]           divcnt;
  logic [NUM_MATCH*ACT_W-1:0] action;
  logic [CNT_W-1:0]           match_values [NUM_MATCH];
  logic [2:0]                 capctl;
  logic [CNT_W-1:0]           capture;
  logic [NUM_MATCH*EXT_W-1:0] ext_action;
  logic [1:0]                 source;
  logic [NUM_MATCH-1:0]       pulse_sel;

  logic [NUM_FLAGS-1:0] next_flags;
  logic [NUM_FLAGS-1:0] next_mask;
  logic [NUM_MATCH-1:0] next_match_outputs;
  logic [DATA_W-1:0]    rd_value;
  logic [NUM_MATCH-1:0] wr_match;
  logic [NUM_MATCH-1:0] hit;
  logic [NUM_MATCH-1:0] hit_int;
  logic [NUM_MATCH-1:0] hit_rst;
  logic [NUM_MATCH-1:0] hit_stop;
  logic                 hit_reset;
  logic                 hit_halt;
  logic                 src_tick;
  logic                 adv;
  logic                 wrap;
  logic                 cap_evt;

  tmc_edge_if edge_bus ();

  tmc_edge u_edge (
    .clk   (clk),
    .reset (reset),
    .clk_en(clk_en),
    .pin   (capture_input),
    .edges (edge_bus.src)
  );

  // Offsets are local to the instance; the system decoder supplies the base. [R14]
  logic wr_flags, wr_ctrl, wr_count, wr_limit, wr_divcnt, wr_action;
  logic wr_capctl, wr_ext, wr_source, wr_pulse, wr_mask;
  assign wr_flags  = wr && addr == OFS_FLAGS;
  assign wr_ctrl   = wr && addr == OFS_CTRL;
  assign wr_count  = wr && addr == OFS_COUNT;
  assign wr_limit  = wr && addr == OFS_LIMIT;
  assign wr_divcnt = wr && addr == OFS_DIVCNT;
  assign wr_action = wr && addr == OFS_ACTION;
  assign wr_capctl = wr && addr == OFS_CAPCTL;
  assign wr_ext    = wr && addr == OFS_EXTMATCH;
  assign wr_source = wr && addr == OFS_SOURCE;
  assign wr_pulse  = wr && addr == OFS_PULSE;
  assign wr_mask   = wr && addr == OFS_MASK;

  // Counter mode steps on synchronised capture pin edges. [R1] [R6] [R16]
  always_comb begin
    case (source)
      SRC_RISE: src_tick = edge_bus.rise;
      SRC_FALL: src_tick = edge_bus.fall;
      SRC_BOTH: src_tick = edge_bus.rise | edge_bus.fall;
      default:  src_tick = 1'b1;
    endcase
  end

  // A disabled or reset-held counter does not advance. [R10] [R17]
  assign adv  = ctrl[CTRL_EN] & ~ctrl[CTRL_RST] & src_tick;
  // Divider at its limit: this tick finishes the count period. [R11] [R12]
  assign wrap = adv && divcnt == limit;

  genvar gi;
  for (gi = 0; gi < NUM_MATCH; gi++) begin : g_match
    logic [ADDR_W-1:0] ofs;
    logic [1:0]        act;
    assign ofs          = OFS_MATCH0 + ADDR_W'(gi) * MATCH_STRIDE;
    assign act          = ext_action[gi*EXT_W +: EXT_W];
    assign wr_match[gi] = wr && addr == ofs;
    // Matches are judged at the end of a count period, so a match gets a full period. [R2]
    assign hit[gi]      = wrap && count == match_values[gi];
    assign hit_int[gi]  = hit[gi] & action[gi*ACT_W+ACT_INT];
    assign hit_rst[gi]  = hit[gi] & action[gi*ACT_W+ACT_RST];
    assign hit_stop[gi] = hit[gi] & action[gi*ACT_W+ACT_STOP];

    always_comb begin
      next_match_outputs[gi] = match_outputs[gi];
      if (wr_ext) begin
        next_match_outputs[gi] = wdata[gi];
      end
      if (pulse_sel[gi]) begin
        // Pulse outputs drop at cycle start unless their value is zero. [R4]
        if (hit_reset) begin
          next_match_outputs[gi] = match_values[gi] == RESET_WORD;
        end else if (hit[gi]) begin
          next_match_outputs[gi] = 1'b1;
        end
      end else if (hit[gi]) begin
        case (act)
          EXT_LOW:    next_match_outputs[gi] = 1'b0;
          EXT_HIGH:   next_match_outputs[gi] = 1'b1;
          EXT_TOGGLE: next_match_outputs[gi] = ~match_outputs[gi];
          default:    next_match_outputs[gi] = match_outputs[gi];
        endcase
      end
    end

    always_ff @(posedge clk) begin
      if (reset) begin
        match_values[gi] <= RESET_WORD;
      end else if (clk_en && wr_match[gi]) begin
        match_values[gi] <= wdata;
      end
    end
  end

  assign hit_reset = |hit_rst; // [R15]
  assign hit_halt  = |hit_stop; // [R15]

  // Capture on the configured pin edges. [R3] [R5]
  assign cap_evt = (edge_bus.rise & capctl[CAP_RISE]) | (edge_bus.fall & capctl[CAP_FALL]);

  // A new event beats a simultaneous clear, so no event is lost. [R9]
  always_comb begin
    next_flags = flags;
    if (wr_flags) begin
      next_flags = flags & ~wdata[NUM_FLAGS-1:0];
    end
    next_flags = next_flags | {cap_evt & capctl[CAP_INT], hit_int};
    next_mask  = wr_mask ? wdata[NUM_FLAGS-1:0] : mask;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      flags <= '0;
      mask  <= '0;
      irq   <= 1'b0;
    end else if (clk_en) begin
      flags <= next_flags;
      mask  <= next_mask;
      irq   <= |(next_flags & next_mask);
    end
  end

  // The gate bit of this instance freezes all state while low. [R8]
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl <= '0;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        ctrl <= wdata[1:0];
      end else if (hit_halt) begin
        ctrl[CTRL_EN] <= 1'b0; // [R15]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      count <= RESET_WORD;
    end else if (clk_en) begin
      if (ctrl[CTRL_RST]) begin
        count <= RESET_WORD; // [R10]
      end else if (wr_count) begin
        count <= wdata;
      end else if (hit_reset) begin
        count <= RESET_WORD; // [R15]
      end else if (wrap && !hit_halt) begin
        count <= count + CNT_W'(1); // [R11] [R18]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      divcnt <= RESET_WORD;
    end else if (clk_en) begin
      if (ctrl[CTRL_RST]) begin
        divcnt <= RESET_WORD; // [R10]
      end else if (wr_divcnt) begin
        divcnt <= wdata; // [R13]
      end else if (wrap) begin
        divcnt <= RESET_WORD; // [R12]
      end else if (adv) begin
        divcnt <= divcnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      capture <= RESET_WORD;
    end else if (clk_en && cap_evt) begin
      capture <= count; // [R5]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      match_outputs <= '0;
    end else if (clk_en) begin
      match_outputs <= next_match_outputs; // [R7]
    end
  end

  // Plain configuration registers.
  always_ff @(posedge clk) begin
    if (reset) begin
      limit      <= RESET_WORD;
      action     <= '0;
      capctl     <= '0;
      ext_action <= '0;
      source     <= SRC_TIMER;
      pulse_sel  <= '0;
    end else if (clk_en) begin
      if (wr_limit) begin
        limit <= wdata;
      end
      if (wr_action) begin
        action <= wdata[NUM_MATCH*ACT_W-1:0];
      end
      if (wr_capctl) begin
        capctl <= wdata[2:0];
      end
      if (wr_ext) begin
        ext_action <= wdata[EXT_LSB +: NUM_MATCH*EXT_W];
      end
      if (wr_source) begin
        source <= wdata[1:0]; // [R16]
      end
      if (wr_pulse) begin
        pulse_sel <= wdata[NUM_MATCH-1:0];
      end
    end
  end

  // Unmapped offsets read as zero.
  always_comb begin
    rd_value = RESET_WORD;
    if (addr == OFS_FLAGS) begin
      rd_value[NUM_FLAGS-1:0] = flags; // [R9]
    end else if (addr == OFS_CTRL) begin
      rd_value[1:0] = ctrl;
    end else if (addr == OFS_COUNT) begin
      rd_value = count;
    end else if (addr == OFS_LIMIT) begin
      rd_value = limit;
    end else if (addr == OFS_DIVCNT) begin
      rd_value = divcnt; // [R13]
    end else if (addr == OFS_ACTION) begin
      rd_value[NUM_MATCH*ACT_W-1:0] = action;
    end else if (addr == OFS_CAPCTL) begin
      rd_value[2:0] = capctl;
    end else if (addr == OFS_CAPTURE) begin
      rd_value = capture;
    end else if (addr == OFS_EXTMATCH) begin
      rd_value[EXT_LSB +: NUM_MATCH*EXT_W] = ext_action;
      rd_value[NUM_MATCH-1:0]              = match_outputs;
    end else if (addr == OFS_SOURCE) begin
      rd_value[1:0] = source;
    end else if (addr == OFS_PULSE) begin
      rd_value[NUM_MATCH-1:0] = pulse_sel;
    end else if (addr == OFS_MASK) begin
      rd_value[NUM_FLAGS-1:0] = mask;
    end
    for (int i = 0; i < NUM_MATCH; i++) begin
      if (wr_match[i] || (rd && addr == OFS_MATCH0 + ADDR_W'(i) * MATCH_STRIDE)) begin
        rd_value = match_values[i];
      end
    end
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= RESET_WORD;
    end else if (clk_en) begin
      rdata <= rd ? rd_value : RESET_WORD;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence stop_match_s;
    clk_en && hit_halt && !wr_ctrl && !hit_reset && !ctrl[CTRL_RST] && !wr_count;
  endsequence

  sequence frozen_s;
    $stable(count) && $stable(divcnt) && $stable(ctrl);
  endsequence

  count_step_a: assert property (clk_en && wrap && !hit_reset && !hit_halt
      && !ctrl[CTRL_RST] && !wr_count |=> count == $past(count) + CNT_W'(1)) // [R11]
    else $error("count did not step at divider limit");
  divider_clear_a: assert property (clk_en && wrap && !wr_divcnt |=> divcnt == RESET_WORD) // [R12]
    else $error("divider not cleared at limit");
  hold_idle_a: assert property (clk_en && !ctrl[CTRL_EN] && !ctrl[CTRL_RST] && !wr_count
      && !wr_divcnt && !wr_ctrl |=> frozen_s) // [R17]
    else $error("disabled counter moved");
  force_reset_a: assert property (clk_en && ctrl[CTRL_RST] |=> count == RESET_WORD
      && divcnt == RESET_WORD) // [R10]
    else $error("counter not held in reset");
  capture_load_a: assert property (clk_en && cap_evt |=> capture == $past(count)) // [R5]
    else $error("capture register missed the count");
  match_stop_a: assert property (stop_match_s |=> !ctrl[CTRL_EN] && $stable(count)) // [R15]
    else $error("stop on match did not halt");
  match_flag_a: assert property (clk_en && |hit_int |=> (flags & $past(hit_int)) == $past(hit_int)) // [R2]
    else $error("match interrupt flag not set");
  irq_level_a: assert property (irq == |(flags & mask)) // [R9]
    else $error("interrupt level disagrees with flags");
  ext_toggle_a: assert property (clk_en && hit[0] && !pulse_sel[0] && !wr_ext
      && ext_action[EXT_W-1:0] == EXT_TOGGLE |=> match_outputs[0] != $past(match_outputs[0])) // [R7]
    else $error("match output did not toggle");
  pulse_set_a: assert property (clk_en && hit[0] && pulse_sel[0] && !hit_reset && !wr_ext
      |=> match_outputs[0]) // [R4]
    else $error("pulse output not set on match");
  gate_freeze_a: assert property (!clk_en |=> frozen_s and $stable(flags)) // [R8]
    else $error("state changed while clock gated");
endmodule : tmc_timer32

// file: tb/tmc_cpu_model.sv
// Processor model that drives the register bus of the timer and notes expected read data.
`timescale 1ns/1ps
module tmc_cpu_model import tmc_pkg::*; (
  input  wire logic              clk,
  output logic      [ADDR_W-1:0] addr,
  output logic      [DATA_W-1:0] wdata,
  output logic                   wr,
  output logic                   rd
);
  logic [DATA_W-1:0] exp_q[$];

  initial begin
    addr  = '0;
    wdata = '0;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  // Between strobes the bus shows inverted values, so a slave that samples late sees garbage.
  task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    addr  <= ~a;
    wdata <= ~d;
  endtask : write_reg

  // The expected word is queued with the request; the bench compares it two cycles later.
  task automatic read_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd   <= 1'b0;
    addr <= ~a;
  endtask : read_reg
endmodule : tmc_cpu_model

// file: tb/tmc_timer32_tb.sv
// Self-checking bench of the 32-bit match/capture timer.
`timescale 1ns/1ps
module tmc_timer32_tb import tmc_pkg::*; ;
  logic                 clk = 1'b0;
  logic                 reset;
  logic                 clk_en;
  logic                 capture_input;
  logic [ADDR_W-1:0]    addr;
  logic [DATA_W-1:0]    wdata;
  logic                 wr;
  logic                 rd;
  logic                 rd_seen = 1'b0;
  logic [DATA_W-1:0]    rdata;
  logic                 irq;
  logic [NUM_MATCH-1:0] match_outputs;
  logic [31:0]          c0;
  logic [31:0]          highs;
  int unsigned          err_count = 0;
  int unsigned          num_checks = 0;
  int unsigned          lim, k, g, n, m, p, w;

  tmc_cpu_model cpu (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

  tmc_timer32 dut (.clk(clk), .reset(reset), .clk_en(clk_en), .addr(addr), .wdata(wdata),
                   .wr(wr), .rd(rd), .capture_input(capture_input), .rdata(rdata),
                   .irq(irq), .match_outputs(match_outputs));

  always #25 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    if (err_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  task automatic wait_irq(input int lim_cycles);
    for (int j = 0; j < lim_cycles && irq !== 1'b1; j++) begin
      @(posedge clk);
      #1;
    end
  endtask : wait_irq

  // Read data stand only in the cycle after the strobe, so the compare happens exactly there.
  always @(posedge clk) begin
    if (rd_seen)
      check(rdata, cpu.exp_q.pop_front());
    rd_seen <= rd;
  end

  initial begin
    #3_000_000;
    err_count++;
    print_verdict();
  end

  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    capture_input = 1'b0;
    void'($urandom(32'h13fa));
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 5; i++)
      cpu.read_reg(ADDR_W'(4 * i), RESET_WORD);
    cpu.read_reg(12'h040, 32'h0000_0000);
    // Prescaled counting; the gated-off cycles must not count and the first run wraps.
    for (int i = 0; i < 4; i++) begin
      lim = (i == 0) ? 0 : $urandom_range(4, 1);
      k = $urandom_range(20, 0);
      g = $urandom_range(8, 1);
      c0 = (i == 0) ? 32'hFFFF_FFFE : $urandom();
      cpu.write_reg(OFS_LIMIT, lim);
      cpu.write_reg(OFS_COUNT, c0);
      cpu.write_reg(OFS_DIVCNT, 32'h0000_0000);
      cpu.write_reg(OFS_CTRL, 32'h0000_0001);
      repeat (k) @(posedge clk);
      clk_en <= 1'b0;
      repeat (g) @(posedge clk);
      clk_en <= 1'b1;
      cpu.write_reg(OFS_CTRL, 32'h0000_0000);
      n = k + 2;
      repeat (6) @(posedge clk);
      cpu.read_reg(OFS_COUNT, c0 + n / (lim + 1));
      cpu.read_reg(OFS_DIVCNT, n % (lim + 1));
    end
    cpu.write_reg(OFS_CTRL, 32'h0000_0003);
    repeat (5) @(posedge clk);
    cpu.write_reg(OFS_CTRL, 32'h0000_0000);
    cpu.read_reg(OFS_COUNT, 32'h0000_0000);
    cpu.read_reg(OFS_DIVCNT, 32'h0000_0000);
    // Each match channel raises its own flag and resets the count.
    cpu.write_reg(OFS_MASK, 32'h0000_001F);
    cpu.write_reg(OFS_LIMIT, 32'h0000_0000);
    for (int ch = 0; ch < 4; ch++) begin
      m = $urandom_range(20, 3);
      cpu.write_reg(OFS_MATCH0 + ADDR_W'(4 * ch), m);
      cpu.write_reg(OFS_ACTION, 32'h3 << (3 * ch));
      cpu.write_reg(OFS_COUNT, 32'h0000_0000);
      cpu.write_reg(OFS_CTRL, 32'h0000_0001);
      wait_irq(60);
      check(irq, 1'b1);
      cpu.write_reg(OFS_CTRL, 32'h0000_0000);
      cpu.read_reg(OFS_FLAGS, 32'h1 << ch);
      cpu.write_reg(OFS_FLAGS, 32'h1 << ch);
      cpu.read_reg(OFS_FLAGS, 32'h0000_0000);
      check(irq, 1'b0);
    end
    // Stop on match of channel 3 while all four pins act on the same hit.
    m = $urandom_range(20, 3);
    for (int ch = 0; ch < 4; ch++)
      cpu.write_reg(OFS_MATCH0 + ADDR_W'(4 * ch), m);
    cpu.write_reg(OFS_EXTMATCH, 32'h0000_01BC);
    @(posedge clk);
    check(match_outputs, 4'hC);
    cpu.write_reg(OFS_ACTION, 32'h0000_0A00);
    cpu.write_reg(OFS_COUNT, 32'h0000_0000);
    cpu.write_reg(OFS_CTRL, 32'h0000_0001);
    wait_irq(60);
    repeat (2) @(posedge clk);
    check(match_outputs, 4'hB);
    cpu.read_reg(OFS_EXTMATCH, 32'h0000_01BB);
    cpu.read_reg(OFS_CTRL, 32'h0000_0000);
    cpu.read_reg(OFS_COUNT, m);
    cpu.read_reg(OFS_FLAGS, 32'h0000_0008);
    cpu.write_reg(OFS_FLAGS, 32'h0000_0008);
    // Single-edge pulse on pin 0, cycle length set by channel 3 resetting the count.
    p = $urandom_range(15, 6);
    w = $urandom_range(p - 1, 1);
    cpu.write_reg(OFS_EXTMATCH, 32'h0000_0000);
    cpu.write_reg(OFS_PULSE, 32'h0000_0001);
    cpu.write_reg(OFS_MATCH0 + ADDR_W'(12), p);
    cpu.write_reg(OFS_MATCH0, w);
    cpu.write_reg(OFS_ACTION, 32'h0000_0400);
    cpu.write_reg(OFS_COUNT, 32'h0000_0000);
    cpu.write_reg(OFS_CTRL, 32'h0000_0001);
    repeat (3 * (p + 1)) @(posedge clk);
    highs = 0;
    repeat (2 * (p + 1)) begin
      @(posedge clk);
      highs = highs + match_outputs[0];
    end
    check(highs, 2 * (p - w));
    cpu.write_reg(OFS_CTRL, 32'h0000_0000);
    cpu.write_reg(OFS_PULSE, 32'h0000_0000);
    cpu.write_reg(OFS_ACTION, 32'h0000_0000);
    // Capture on a rising edge only; the masked flag must not reach the interrupt line.
    c0 = $urandom();
    cpu.write_reg(OFS_COUNT, c0);
    cpu.write_reg(OFS_CAPCTL, 32'h0000_0005);
    cpu.write_reg(OFS_MASK, 32'h0000_0000);
    capture_input <= 1'b1;
    repeat (8) @(posedge clk);
    cpu.read_reg(OFS_CAPTURE, c0);
    cpu.read_reg(OFS_FLAGS, 32'h0000_0010);
    #1;
    check(irq, 1'b0);
    cpu.write_reg(OFS_MASK, 32'h0000_0010);
    repeat (2) @(posedge clk);
    #1;
    check(irq, 1'b1);
    cpu.write_reg(OFS_COUNT, ~c0);
    capture_input <= 1'b0;
    repeat (8) @(posedge clk);
    cpu.read_reg(OFS_CAPTURE, c0);
    cpu.write_reg(OFS_FLAGS, 32'h0000_0010);
    repeat (2) @(posedge clk);
    #1;
    check(irq, 1'b0);
    // Falling-edge capture only: the rising edge must leave the capture register alone.
    cpu.write_reg(OFS_CAPCTL, 32'h0000_0002);
    capture_input <= 1'b1;
    repeat (8) @(posedge clk);
    cpu.read_reg(OFS_CAPTURE, c0);
    capture_input <= 1'b0;
    repeat (8) @(posedge clk);
    cpu.read_reg(OFS_CAPTURE, ~c0);
    cpu.read_reg(OFS_FLAGS, 32'h0000_0000);
    // Counter mode: the capture pin replaces the prescaled clock, per selected edge.
    cpu.write_reg(OFS_CAPCTL, 32'h0000_0000);
    for (int s = 1; s < 4; s++) begin
      n = $urandom_range(5, 2);
      cpu.write_reg(OFS_COUNT, 32'h0000_0000);
      cpu.write_reg(OFS_SOURCE, s);
      cpu.write_reg(OFS_CTRL, 32'h0000_0001);
      repeat (n) begin
        capture_input <= 1'b1;
        repeat (4) @(posedge clk);
        capture_input <= 1'b0;
        repeat (4) @(posedge clk);
      end
      repeat (6) @(posedge clk);
      cpu.write_reg(OFS_CTRL, 32'h0000_0000);
      cpu.read_reg(OFS_COUNT, (s == 3) ? 2 * n : n);
    end
    repeat (3) @(posedge clk);
    print_verdict();
  end
endmodule : tmc_timer32_tb
